// ===== sixteen_bit_interval_timer.sv
// Purpose: 16-bit interval timer and event counter, Wishbone slave
// Assumes: all inputs synchronous to core_clk; core_clk is the
//          instruction and peripheral clock
// Notes:   one-cycle ack; period match raises a sticky status bit
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sixteen_bit_interval_timer (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Count and gate inputs
  input  wire logic        external_count_input,
  input  wire logic        gate_in,
  // Chip power state
  input  wire logic        cpu_idle,
  // Interrupt
  output logic             irq
);

  // ==========================================================
  // Registers
  timer_pkg::ctrl_t ctrl_ff;
  timer_pkg::ctrl_t nxt_ctrl;
  logic [15:0]      count_ff;
  logic [15:0]      nxt_count;
  logic [15:0]      period_ff;
  logic [15:0]      nxt_period;
  logic [15:0]      sts_ff;
  logic [15:0]      nxt_sts;
  logic [15:0]      mask_ff;
  logic [15:0]      nxt_mask;
  logic             ack_ff;
  logic [31:0]      dat_ff;
  logic [31:0]      nxt_dat;
  logic             irq_ff;

  // Count path state
  logic             ext_prev_ff;
  logic             sy1_ff;
  logic             sy2_ff;
  logic             sy3_ff;

  // ==========================================================
  // Bus decode
  logic        access;
  logic        wr;
  logic        rd;
  logic        hit_ctrl;
  logic        hit_count;
  logic        hit_period;
  logic        hit_status;
  logic        hit_mask;
  logic [15:0] wdat;
  logic [1:0]  wsel;
  logic [15:0] rd_mux;

  assign access     = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr         = access & wb_we_i;
  assign rd         = access & ~wb_we_i;
  assign hit_ctrl   = (wb_adr_i == timer_pkg::ADR_CTRL);
  assign hit_count  = (wb_adr_i == timer_pkg::ADR_COUNT);
  assign hit_period = (wb_adr_i == timer_pkg::ADR_PERIOD);
  assign hit_status = (wb_adr_i == timer_pkg::ADR_STATUS);
  assign hit_mask   = (wb_adr_i == timer_pkg::ADR_MASK);
  assign wdat       = wb_dat_i[15:0];
  assign wsel       = wb_sel_i[1:0];

  // Unmapped addresses read zero
  assign rd_mux = hit_ctrl   ? timer_pkg::ctrl_pack(ctrl_ff) :
                  hit_count  ? count_ff  :
                  hit_period ? period_ff :
                  hit_status ? sts_ff    :
                  hit_mask   ? mask_ff   :
                  timer_pkg::ZERO16;
  assign nxt_dat = rd ? {timer_pkg::ZERO16, rd_mux} : {32{1'b0}};

  // ==========================================================
  // Control register
  logic [15:0] ctrl_wval;

  // Only implemented bits survive the unpack
  assign ctrl_wval = timer_pkg::merge16(timer_pkg::ctrl_pack(ctrl_ff),
                                        wdat, wsel);
  assign nxt_ctrl  = (wr && hit_ctrl) ? timer_pkg::ctrl_unpack(ctrl_wval)
                                      : ctrl_ff;

  // ==========================================================
  // Count source selection
  logic run_active;
  logic ext_rise;
  logic int_in;
  logic pre_in;
  logic psc_pulse;
  logic psc_tog;
  logic sync_mode;
  logic sync_tick;
  logic tick;
  logic adv;

  assign run_active = ctrl_ff.count_run &
                      ~(ctrl_ff.idle_halt & cpu_idle);
  assign ext_rise   = external_count_input & ~ext_prev_ff;
  // Gate only matters for the internal source
  assign int_in     = ~ctrl_ff.gate_accumulate_en | gate_in;
  assign pre_in     = run_active & (ctrl_ff.clock_source_sel ? ext_rise
                                                             : int_in);
  assign sync_mode  = ctrl_ff.clock_source_sel & ctrl_ff.ext_clk_sync_sel;
  assign sync_tick  = sy2_ff ^ sy3_ff;
  // Resync costs two extra cycles of latency on each count
  assign tick       = sync_mode ? sync_tick : psc_pulse;
  assign adv        = tick & run_active;

  timer_prescaler u_prescaler (
    .core_clk   (core_clk),
    .reset      (reset),
    .in_pulse   (pre_in),
    .clear      (~ctrl_ff.count_run),
    .sel        (ctrl_ff.prescale_sel),
    .out_pulse  (psc_pulse),
    .out_toggle (psc_tog)
  );

  // ==========================================================
  // Counter and period
  logic cnt_wr;
  logic cnt_lock;
  logic cnt_wr_ok;
  logic match;

  assign cnt_wr    = wr & hit_count & (|wsel);
  assign cnt_lock  = sync_mode & ctrl_ff.count_run;
  assign cnt_wr_ok = cnt_wr & ~cnt_lock;
  assign match     = adv & (count_ff == period_ff);

  // Software write beats a same-cycle count
  assign nxt_count = cnt_wr_ok ? timer_pkg::merge16(count_ff, wdat, wsel) :
                     match     ? timer_pkg::COUNT_RESET :
                     adv       ? count_ff + timer_pkg::ONE16 :
                     count_ff;
  assign nxt_period = (wr && hit_period) ? timer_pkg::merge16(period_ff, wdat, wsel)
                                         : period_ff;

  // ==========================================================
  // Interrupt status, set wins over write-one-clear
  logic [15:0] sts_clr;
  logic [15:0] sts_set;

  assign sts_clr  = (wr && hit_status) ? timer_pkg::merge16(timer_pkg::ZERO16, wdat, wsel)
                                       : timer_pkg::ZERO16;
  assign sts_set  = {{15{1'b0}}, match};
  assign nxt_sts  = ((sts_ff & ~sts_clr) | sts_set) & timer_pkg::IRQ_MASK;
  assign nxt_mask = ((wr && hit_mask) ? timer_pkg::merge16(mask_ff, wdat, wsel)
                                      : mask_ff) & timer_pkg::IRQ_MASK;

  // ==========================================================
  // Flip-flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_ff <= timer_pkg::ctrl_unpack(timer_pkg::CTRL_RESET);
      count_ff <= timer_pkg::COUNT_RESET;
      period_ff <= timer_pkg::PERIOD_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      count_ff <= nxt_count;
      period_ff <= nxt_period;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sts_ff <= timer_pkg::ZERO16;
      mask_ff <= timer_pkg::ZERO16;
      irq_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      mask_ff <= nxt_mask;
      irq_ff <= |(nxt_sts & nxt_mask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
      dat_ff <= {32{1'b0}};
    end else begin
      ack_ff <= access;
      dat_ff <= nxt_dat;
    end
  end

  // First stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_prev_ff <= 1'b0;
      sy1_ff <= 1'b0;
      sy2_ff <= 1'b0;
      sy3_ff <= 1'b0;
    end else begin
      ext_prev_ff <= external_count_input;
      sy1_ff <= psc_tog;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign irq      = irq_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_stop_holds_count: assert property (
    !ctrl_ff.count_run && !cnt_wr |=> $stable(count_ff))
    else $error("counter moved while stopped");

  a_idle_halt_freeze: assert property (
    ctrl_ff.idle_halt && cpu_idle && !cnt_wr |=> $stable(count_ff))
    else $error("counter moved in idle with halt set");

  a_gate_ext_ignored: assert property (
    ctrl_ff.clock_source_sel && ctrl_ff.gate_accumulate_en && !gate_in
    && run_active && ext_rise |-> pre_in)
    else $error("gate blocked an external count");

  a_sync_two_stage: assert property (
    sync_mode && $changed(psc_tog) ##1 sync_mode[*2] |-> ##0 tick)
    else $error("resynchronised count not seen after two cycles");

  a_async_direct: assert property (
    ctrl_ff.clock_source_sel && !ctrl_ff.ext_clk_sync_sel && psc_pulse
    |-> tick)
    else $error("asynchronous count was delayed");

  a_internal_every: assert property (
    !ctrl_ff.clock_source_sel && !ctrl_ff.gate_accumulate_en && run_active
    |-> pre_in)
    else $error("internal clock not fed to prescaler");

  a_sync_write_lock: assert property (
    cnt_wr && cnt_lock && !adv |=> $stable(count_ff))
    else $error("counter write taken in synchronous counter mode");

  a_reserved_read_zero: assert property (
    ack_ff && !wb_we_i && hit_ctrl |-> (wb_dat_o[15:0] & ~timer_pkg::CTRL_MASK) == 16'h0000)
    else $error("unimplemented control bit read as one");

  a_reset_clears_ctrl: assert property (
    $past(reset) |-> timer_pkg::ctrl_pack(ctrl_ff) == timer_pkg::CTRL_RESET)
    else $error("control not cleared by reset");

  a_count_increment: assert property (
    adv && !cnt_wr_ok && count_ff != period_ff |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("counter did not step by one");

  a_gate_low_holds: assert property (
    !ctrl_ff.clock_source_sel && ctrl_ff.gate_accumulate_en && !gate_in
    |-> !pre_in)
    else $error("gated timer counted with gate low");

  a_match_wraps_flags: assert property (
    match && !cnt_wr_ok |=> count_ff == timer_pkg::COUNT_RESET && sts_ff[timer_pkg::STS_MATCH])
    else $error("period match did not wrap and flag");

  a_irq_level: assert property (
    irq == |(sts_ff & mask_ff))
    else $error("interrupt level does not follow status and mask");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack stood more than one cycle");

  c_period_match: cover property (match);
  c_sync_count: cover property (sync_mode && adv);
  c_gated_count: cover property (ctrl_ff.gate_accumulate_en && !ctrl_ff.clock_source_sel && adv);
  c_write_locked: cover property (cnt_wr && cnt_lock);
  c_idle_halted: cover property (ctrl_ff.idle_halt && cpu_idle && ctrl_ff.count_run);

endmodule

// ===== timer_pkg.sv
// Purpose: Shared constants, types and helpers of the interval timer
// Assumes: 16-bit registers in the low half of a 32-bit Wishbone word
// Notes:   Control fields are packed into one struct
package timer_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_COUNT  = 8'h04;
  localparam logic [7:0] ADR_PERIOD = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam logic [7:0] ADR_MASK   = 8'h10;

  // ==========================================================
  // Control field positions
  localparam int BIT_RUN   = 15;
  localparam int BIT_IDLE  = 13;
  localparam int BIT_GATE  = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_SYNC  = 2;
  localparam int BIT_SRC   = 1;
  localparam logic [15:0] CTRL_MASK = 16'hA076;

  // ==========================================================
  // Reset values
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [15:0] ONE16        = 16'h0001;

  // ==========================================================
  // Interrupt status layout
  localparam int          STS_MATCH = 0;
  localparam logic [15:0] IRQ_MASK  = 16'h0001;

  // ==========================================================
  // Prescaler codes and terminal counts
  localparam logic [1:0] PS_DIV1   = 2'h0;
  localparam logic [1:0] PS_DIV8   = 2'h1;
  localparam logic [1:0] PS_DIV64  = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [7:0] LIM_DIV1   = 8'h00;
  localparam logic [7:0] LIM_DIV8   = 8'h07;
  localparam logic [7:0] LIM_DIV64  = 8'h3F;
  localparam logic [7:0] LIM_DIV256 = 8'hFF;

  typedef struct packed {
    logic       count_run;
    logic       idle_halt;
    logic       gate_accumulate_en;
    logic [1:0] prescale_sel;
    logic       ext_clk_sync_sel;
    logic       clock_source_sel;
  } ctrl_t;

  function automatic logic [15:0] ctrl_pack(input ctrl_t c);
    logic [15:0] w;
    w = ZERO16;
    w[BIT_RUN] = c.count_run;
    w[BIT_IDLE] = c.idle_halt;
    w[BIT_GATE] = c.gate_accumulate_en;
    w[BIT_PS_HI:BIT_PS_LO] = c.prescale_sel;
    w[BIT_SYNC] = c.ext_clk_sync_sel;
    w[BIT_SRC] = c.clock_source_sel;
    return w;
  endfunction

  function automatic ctrl_t ctrl_unpack(input logic [15:0] w);
    ctrl_t c;
    c.count_run = w[BIT_RUN];
    c.idle_halt = w[BIT_IDLE];
    c.gate_accumulate_en = w[BIT_GATE];
    c.prescale_sel = w[BIT_PS_HI:BIT_PS_LO];
    c.ext_clk_sync_sel = w[BIT_SYNC];
    c.clock_source_sel = w[BIT_SRC];
    return c;
  endfunction

  function automatic logic [7:0] div_limit(input logic [1:0] s);
    logic [7:0] l;
    l = LIM_DIV1;
    unique case (s)
      PS_DIV1:   l = LIM_DIV1;
      PS_DIV8:   l = LIM_DIV8;
      PS_DIV64:  l = LIM_DIV64;
      PS_DIV256: l = LIM_DIV256;
    endcase
    return l;
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    logic [15:0] m;
    m = old_v;
    if (sel[0]) m[7:0] = new_v[7:0];
    if (sel[1]) m[15:8] = new_v[15:8];
    return m;
  endfunction

endpackage

// ===== timer_prescaler.sv
// Purpose: Input prescaler of the interval timer
// Assumes: in_pulse is a one-cycle count request
// Notes:   out_toggle flips on each output event for the resync path
`timescale 1ns/1ps
module timer_prescaler (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Count input and setup
  input  wire logic       in_pulse,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  // Divided output
  output logic            out_pulse,
  output logic            out_toggle
);

  logic [7:0] cnt_ff;
  logic       pulse_ff;
  logic       tog_ff;
  logic [7:0] limit;
  logic       wrap;

  assign limit      = timer_pkg::div_limit(sel);
  assign wrap       = in_pulse & (cnt_ff >= limit);
  assign out_pulse  = pulse_ff;
  assign out_toggle = tog_ff;

  // ==========================================================
  // Divider
  always_ff @(posedge core_clk) begin
    if (reset || clear) begin
      cnt_ff <= timer_pkg::LIM_DIV1;
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= wrap;
      if (wrap) cnt_ff <= timer_pkg::LIM_DIV1;
      else if (in_pulse) cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Toggle is not cleared so a stop cannot fake a resync edge
  always_ff @(posedge core_clk) begin
    if (reset) tog_ff <= 1'b0;
    else if (wrap && !clear) tog_ff <= ~tog_ff;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_prescale_wrap: assert property (
    in_pulse && !clear && cnt_ff == limit |=> out_pulse && cnt_ff == 8'h00)
    else $error("prescaler missed its terminal count");
  a_prescale_hold: assert property (
    !(in_pulse && cnt_ff >= limit) |=> !out_pulse)
    else $error("prescaler pulsed early");

endmodule

// ===== ext_count_source.sv
// Purpose: Pulse source standing on the external count pin
// Assumes: Pin level is sampled on core_clk by the timer
// Notes:   Each pulse is one cycle high, then gap plus one cycles low
`timescale 1ns/1ps
module ext_count_source (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Burst request
  input  wire logic       go,
  input  wire logic [7:0] n_edges,
  input  wire logic [3:0] gap,
  // Pin and status
  output logic            pin,
  output logic            busy
);
  logic [7:0] left_ff;
  logic [3:0] wait_ff;

  assign busy = (left_ff != 8'h00) || pin || (wait_ff != 4'h0);

  // ==========================================================
  // Burst engine; idle level of the pin is low
  always_ff @(posedge core_clk) begin
    if (reset || go) begin
      left_ff <= reset ? 8'h00 : n_edges;
      wait_ff <= 4'h0;
      pin     <= 1'b0;
    end else if (pin) begin
      pin     <= 1'b0;
      wait_ff <= gap; // Low at least one cycle between edges
    end else if (wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
    end else if (left_ff != 8'h00) begin
      pin     <= 1'b1;
      left_ff <= left_ff - 8'h01;
    end
  end
endmodule

// ===== test_sixteen_bit_interval_timer.sv
// Purpose: Self-checking bench of the interval timer
// Assumes: One-cycle Wishbone ack; 50 ns clock
// Notes:   Rates are judged from count deltas between timed reads
`timescale 1ns/1ps
module test_sixteen_bit_interval_timer;
  logic        core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        external_count_input, gate_in, cpu_idle, irq;
  logic        go, busy;
  logic [7:0]  n_edges;
  logic [3:0]  gap;
  int          errors, n_tests, t_ack;
  int          cyc_cnt = 0;

  sixteen_bit_interval_timer dut_u (.core_clk(core_clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_count_input(external_count_input), .gate_in(gate_in),
    .cpu_idle(cpu_idle), .irq(irq));
  ext_count_source src_u (.core_clk(core_clk), .reset(reset), .go(go),
    .n_edges(n_edges), .gap(gap), .pin(external_count_input), .busy(busy));

  // ==========================================================
  // Clock, cycle stamp, expectations
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc_cnt <= cyc_cnt + 1;

  function automatic int div_of(input int p);
    return (p == 3) ? 256 : (p == 2) ? 64 : (p == 1) ? 8 : 1;
  endfunction
  function automatic logic [15:0] cw(input int run, idl, gt, ps, syn, src);
    return 16'((run << 15) | (idl << 13) | (gt << 6) | (ps << 4) | (syn << 2) | (src << 1));
  endfunction

  // ==========================================================
  // Reporting
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic check_rng(input string what, input int lo, hi, input logic [15:0] got);
    n_tests++;
    if ($isunknown(got) || !(got >= lo && got <= hi)) begin
      $display("ERROR %s expected %0d..%0d seen %h", what, lo, hi, got);
      errors++;
    end
  endtask

  // ==========================================================
  // Wishbone classic master
  task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] d,
                    output logic [15:0] q);
    int i;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o[15:0];
    t_ack = cyc_cnt;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 20) begin
      $display("ERROR bus ack expected 1 seen 0");
      errors++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, adr, d, q);
  endtask
  task automatic rd(input logic [7:0] adr, output logic [15:0] q);
    wb(1'b0, adr, 16'h0000, q);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ==========================================================
  // Main sequence
  logic [7:0]  adrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [15:0] rst_v[6] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] a, b, v, last;
  int          dv, dt, n, i;

  initial begin
    {reset, wb_cyc_i, wb_stb_i, wb_we_i, go} = 5'h10;
    {wb_adr_i, wb_dat_i, n_edges, gap} = '0;
    {gate_in, cpu_idle, errors, n_tests} = '0;
    wb_sel_i = 4'h3;
    void'($urandom(32'h0410288c));
    tick(8);
    reset <= 1'b0;
    check("irq after reset", 16'h0000, {15'h0000, irq});
    foreach (adrs[k]) begin
      rd(adrs[k], a);
      check("reset value", rst_v[k], a);
    end
    // Unimplemented control bits, corner then random
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? 16'h5F89 : 16'($urandom) & 16'h7FFF;
      wr(timer_pkg::ADR_CTRL, v);
      rd(timer_pkg::ADR_CTRL, a);
      check("ctrl readback", v & timer_pkg::CTRL_MASK, a);
    end
    wr(8'h14, 16'hFFFF);
    rd(timer_pkg::ADR_CTRL, b);
    check("ctrl after unmapped write", a, b);
    // Internal clock, every prescale code
    for (int p = 0; p < 4; p++) begin
      dv = div_of(p);
      wr(timer_pkg::ADR_CTRL, 16'h0000);
      wr(timer_pkg::ADR_COUNT, 16'h0000);
      wr(timer_pkg::ADR_CTRL, cw(1, 0, 0, p, 1, 0));
      tick(4);
      rd(timer_pkg::ADR_COUNT, a);
      dt = t_ack;
      tick(8 * dv);
      rd(timer_pkg::ADR_COUNT, b);
      dt = t_ack - dt;
      check_rng("timer rate", dt / dv, dt / dv + 1, b - a);
      wr(timer_pkg::ADR_CTRL, cw(0, 0, 0, p, 0, 0));
      tick(6);
      rd(timer_pkg::ADR_COUNT, a);
      tick(30);
      rd(timer_pkg::ADR_COUNT, b);
      check("stopped count", a, b);
    end
    // Gate and idle hold the count; idle without halt keeps it going
    for (int m = 0; m < 2; m++) begin
      gate_in  <= 1'b0;
      cpu_idle <= (m == 0);
      wr(timer_pkg::ADR_CTRL, cw(1, 1 - m, m, 0, 0, 0));
      tick(8);
      rd(timer_pkg::ADR_COUNT, a);
      tick(40);
      rd(timer_pkg::ADR_COUNT, b);
      check("held count", a, b);
      gate_in <= 1'b1;
      wr(timer_pkg::ADR_CTRL, cw(1, 0, m, 0, 0, 0));
      tick(20);
      rd(timer_pkg::ADR_COUNT, b);
      check_rng("resumed count", 20, 40, b - a);
    end
    cpu_idle <= 1'b0;
    gate_in  <= 1'b0;
    // External pin, both sync settings, gate bit set but ignored
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 2; p++) begin
        wr(timer_pkg::ADR_CTRL, 16'h0000);
        wr(timer_pkg::ADR_COUNT, 16'h0000);
        wr(timer_pkg::ADR_CTRL, cw(1, 0, 1, p, s, 1));
        n = $urandom_range(40, 8);
        n_edges <= 8'(n);
        gap     <= 4'($urandom_range(3, 1));
        go      <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(1);
        for (i = 0; i < 400 && busy; i++) tick(1);
        if (i == 400) begin
          $display("ERROR pulse burst expected idle seen busy");
          errors++;
          conclude();
        end
        tick(8);
        rd(timer_pkg::ADR_COUNT, a);
        last = 16'(n / div_of(p));
        check("pin count", last, a);
      end
    end
    // Counter writes while in synchronous counter mode, then async
    wr(timer_pkg::ADR_COUNT, 16'h1234);
    rd(timer_pkg::ADR_COUNT, a);
    check("count write ignored", last, a);
    wr(timer_pkg::ADR_CTRL, cw(1, 0, 0, 0, 0, 1));
    wr(timer_pkg::ADR_COUNT, 16'h1234);
    rd(timer_pkg::ADR_COUNT, a);
    check("count write taken", 16'h1234, a);
    // Period match, sticky status, mask and irq
    wr(timer_pkg::ADR_CTRL, 16'h0000);
    wr(timer_pkg::ADR_PERIOD, 16'h0005);
    wr(timer_pkg::ADR_COUNT, 16'h0000);
    wr(timer_pkg::ADR_MASK, 16'h0001);
    wr(timer_pkg::ADR_CTRL, cw(1, 0, 0, 0, 0, 0));
    for (i = 0; i < 30 && irq !== 1'b1; i++) tick(1);
    check("irq on match", 16'h0001, {15'h0000, irq});
    for (i = 0; i < 4; i++) begin
      rd(timer_pkg::ADR_COUNT, a);
      check_rng("count within period", 0, 5, a);
    end
    rd(timer_pkg::ADR_STATUS, a);
    check("status set", 16'h0001, a);
    wr(timer_pkg::ADR_CTRL, 16'h0000);
    wr(timer_pkg::ADR_STATUS, 16'h0001);
    rd(timer_pkg::ADR_STATUS, a);
    check("status cleared", 16'h0000, a);
    check("irq cleared", 16'h0000, {15'h0000, irq});
    wr(timer_pkg::ADR_MASK, 16'h0000);
    wr(timer_pkg::ADR_CTRL, cw(1, 0, 0, 0, 0, 0));
    tick(30);
    rd(timer_pkg::ADR_STATUS, a);
    check("masked status", 16'h0001, a);
    check("masked irq", 16'h0000, {15'h0000, irq});
    wr(timer_pkg::ADR_CTRL, 16'h0000);
    conclude();
  end
endmodule
